// >>> counter_array_params.svh
// Offsets, field positions, reset values and counts of the counter array time base
`ifndef COUNTER_ARRAY_PARAMS_SVH
`define COUNTER_ARRAY_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_CONTROL 8'hd8
`define OFS_MODE 8'hd9
`define OFS_COUNT_HIGH 8'hf9
`define OFS_COUNT_LOW 8'he9
`define OFS_RELOAD_HIGH 8'hcf
`define OFS_RELOAD_LOW 8'hce
`define OFS_IRQ_STATUS 8'hc0
`define OFS_IRQ_MASK 8'hc1
`define OFS_PIN_CONTROL 8'hc2

// ----------------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_COUNT 16'h0000
`define BIT_OVERFLOW_FLAG 7
`define BIT_STATUS_OVERFLOW 0
`define BIT_STATUS_MODULE 1
`define BIT_PIN_OUT_ENABLE 0
`define COUNT_ALL_ONES 16'hffff
`define CAPTURE_CAPABLE 8'h3f

// ----------------------------------------------------------------------------
// Prescaler counts
// ----------------------------------------------------------------------------
`define DIV_SLOW 12
`define DIV_FAST 2

`endif

// >>> counter_array_pkg.sv
// Types shared by the counter array time base
package counter_array_pkg;

    // Count source codes of the mode register
    typedef enum logic [2:0] {
        SRC_SYS_DIV12 = 3'b000,
        SRC_SYS_DIV2 = 3'b001,
        SRC_TIMER0_OVF = 3'b010,
        SRC_EXT_PIN = 3'b011,
        SRC_MIXED_CLK = 3'b100,
        SRC_SYS_DIV1 = 3'b101,
        SRC_SERIAL0_OVF = 3'b110,
        SRC_MASTER_DIV = 3'b111
    } source_t;

    // Mode register layout, bit 7 down to bit 0
    typedef struct packed {
        logic idle_gate_off;
        logic buffer_pair45_enable;
        logic buffer_pair23_enable;
        logic buffer_pair01_enable;
        source_t source;
        logic overflow_irq_enable;
    } mode_reg_t;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic overflow_flag;
        logic counter_run;
        logic [5:0] module_flags;
    } control_reg_t;

    // Count source inputs that arrive from elsewhere in the chip
    typedef struct packed {
        logic timer0_overflow;
        logic ext_count_pin;
        logic mixed_clock_out;
        logic serial0_baud_overflow;
        logic master_divider_out;
    } source_in_t;

    // Modes of the compare/capture modules as seen by the buffer logic
    typedef struct packed {
        logic [7:0] capture;
        logic [7:0] pwm;
        logic [7:0] compare_on_pwm_match;
    } module_modes_t;

endpackage : counter_array_pkg

// >>> counter_array_time_base.sv
// Time base, global control and flag register of the eight-module counter array
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`include "counter_array_params.svh"

module counter_array_time_base
    import counter_array_pkg::*;
#(
    parameter int SLOW_DIVIDE = `DIV_SLOW, // Divider for the slow internal source
    parameter int NUM_MODULES = 8 // Modules sharing the time base
) (
    input wire logic clk, // System clock, 100 MHz
    input wire logic reset_n, // Asynchronous reset, active low
    input wire logic [7:0] addr, // Register address
    input wire logic [7:0] wdata, // Register write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [7:0] rdata_q, // Read data, the cycle after rd
    input wire source_in_t sources, // External count sources
    input wire logic processor_idle, // Processor in idle mode
    input wire logic [5:0] module_event, // Match or capture pulses of modules 0..5
    input wire module_modes_t module_modes, // Mode of each module
    input wire logic [7:0] module_pin_use, // Module claims its port pin
    input wire logic [7:0] module_pin_drive, // Level the module drives
    input wire logic [7:0] gpio_drive, // Level the ordinary port drives
    output logic [7:0] port_out_q, // Resulting port pin levels
    output logic [15:0] time_base_q, // Shared count for all modules
    output logic [2:0] buffer_active_q, // Buffer mode in force per pair
    output logic [7:0] capture_allowed_q, // Capture mode accepted per module
    output logic overflow_irq_q, // Overflow interrupt request
    output logic overflow_pin_q, // Toggle output at the port pin
    output logic overflow_pin_oe_q, // Output enable of that pin
    output logic irq_q // Sticky status interrupt
);

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    if (SLOW_DIVIDE < 2 || SLOW_DIVIDE > 255) begin : g_bad_divide
        $error("SLOW_DIVIDE must lie between 2 and 255");
    end
    if (NUM_MODULES != 8) begin : g_bad_modules
        $error("NUM_MODULES must be 8");
    end

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    control_reg_t control_q;
    mode_reg_t mode_q;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [7:0] reload_high_q;
    logic [7:0] reload_low_q;
    logic [1:0] irq_status_q;
    logic [1:0] irq_mask_q;
    logic pin_enable_q;
    logic toggle_q;
    logic [7:0] slow_div_q;
    logic fast_div_q;
    logic slow_tick;
    logic ext_prev_q;
    logic mixed_prev_q;
    logic master_prev_q;
    logic source_tick;
    logic count_enable;
    logic overflow;
    logic wr_control;
    logic wr_mode;
    logic [7:0] capture_mode;
    logic [7:0] pair_ok;

    localparam logic [7:0] SLOW_LAST = 8'(SLOW_DIVIDE - 1);

    assign wr_control = wr && (addr == `OFS_CONTROL);
    assign wr_mode = wr && (addr == `OFS_MODE);

    // ------------------------------------------------------------------------
    // Internal prescalers
    // ------------------------------------------------------------------------
    // Free running so a source change never waits on a stale count
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            slow_div_q <= `RST_BYTE;
        end else if (slow_div_q == SLOW_LAST) begin
            slow_div_q <= `RST_BYTE;
        end else begin
            slow_div_q <= slow_div_q + 8'h01;
        end
    end

    assign slow_tick = (slow_div_q == SLOW_LAST);

    // Divide by two is a plain toggle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fast_div_q <= 1'b0;
        end else begin
            fast_div_q <= ~fast_div_q;
        end
    end

    // ------------------------------------------------------------------------
    // Edge detection of external sources
    // ------------------------------------------------------------------------
    // Inputs are synchronous already; one stage of history gives the edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_prev_q <= 1'b0;
            mixed_prev_q <= 1'b0;
            master_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= sources.ext_count_pin;
            mixed_prev_q <= sources.mixed_clock_out;
            master_prev_q <= sources.master_divider_out;
        end
    end

    // Source select; the mixed and master clocks must be slow enough to
    // sample, else edges are lost
    always_comb begin
        unique case (mode_q.source)
            SRC_SYS_DIV12: source_tick = slow_tick;
            SRC_SYS_DIV2: source_tick = fast_div_q;
            SRC_SYS_DIV1: source_tick = 1'b1;
            SRC_TIMER0_OVF: source_tick = sources.timer0_overflow;
            SRC_EXT_PIN: source_tick = ext_prev_q & ~sources.ext_count_pin;
            SRC_MIXED_CLK: source_tick = ~mixed_prev_q & sources.mixed_clock_out;
            SRC_SERIAL0_OVF: source_tick = sources.serial0_baud_overflow;
            SRC_MASTER_DIV: source_tick = ~master_prev_q & sources.master_divider_out;
        endcase
    end

    // Run bit and idle gating both qualify the tick
    assign count_enable = source_tick && control_q.counter_run
        && !(mode_q.idle_gate_off && processor_idle);

    // Wrap from all ones is the overflow
    assign overflow = count_enable && (count_q == `COUNT_ALL_ONES);

    // ------------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------------
    // Software writes to a count byte win over counting in that cycle
    always_comb begin
        count_d = count_q;
        if (overflow) begin
            count_d = {reload_high_q, reload_low_q};
        end else if (count_enable) begin
            count_d = count_q + 16'h0001;
        end
        if (wr && addr == `OFS_COUNT_HIGH) begin
            count_d[15:8] = wdata;
        end
        if (wr && addr == `OFS_COUNT_LOW) begin
            count_d[7:0] = wdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= `RST_COUNT;
        end else begin
            count_q <= count_d;
        end
    end

    // Reload pair
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reload_high_q <= `RST_BYTE;
            reload_low_q <= `RST_BYTE;
        end else begin
            if (wr && addr == `OFS_RELOAD_HIGH) begin
                reload_high_q <= wdata;
            end
            if (wr && addr == `OFS_RELOAD_LOW) begin
                reload_low_q <= wdata;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Control and mode registers
    // ------------------------------------------------------------------------
    // Hardware sets win over a software clear in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            control_q <= control_reg_t'(`RST_BYTE);
        end else begin
            if (wr_control) begin
                control_q <= control_reg_t'(wdata);
            end
            if (overflow) begin
                control_q.overflow_flag <= 1'b1;
            end
            if (wr_control) begin
                control_q.module_flags <= wdata[5:0] | module_event;
            end else begin
                control_q.module_flags <= control_q.module_flags | module_event;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= mode_reg_t'(`RST_BYTE);
        end else if (wr_mode) begin
            mode_q <= mode_reg_t'(wdata);
        end
    end

    // ------------------------------------------------------------------------
    // Overflow toggle output
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_enable_q <= 1'b0;
            toggle_q <= 1'b0;
        end else begin
            if (wr && addr == `OFS_PIN_CONTROL) begin
                pin_enable_q <= wdata[`BIT_PIN_OUT_ENABLE];
            end
            if (overflow) begin
                toggle_q <= ~toggle_q;
            end
        end
    end

    // Pin follows the toggle only while enabled; it idles low otherwise
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            overflow_pin_q <= 1'b0;
            overflow_pin_oe_q <= 1'b0;
        end else begin
            overflow_pin_q <= pin_enable_q & toggle_q;
            overflow_pin_oe_q <= pin_enable_q;
        end
    end

    // ------------------------------------------------------------------------
    // Module support: capture mask, buffer pairs, pins, time base
    // ------------------------------------------------------------------------
    // Modules 6 and 7 have no capture path, so their capture bit is ignored
    assign capture_mode = module_modes.capture & `CAPTURE_CAPABLE;
    assign pair_ok = capture_mode | module_modes.pwm | module_modes.compare_on_pwm_match;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            capture_allowed_q <= `RST_BYTE;
            buffer_active_q <= 3'b000;
            port_out_q <= `RST_BYTE;
        end else begin
            capture_allowed_q <= capture_mode;
            buffer_active_q[0] <= mode_q.buffer_pair01_enable & pair_ok[0] & pair_ok[1];
            buffer_active_q[1] <= mode_q.buffer_pair23_enable & pair_ok[2] & pair_ok[3];
            buffer_active_q[2] <= mode_q.buffer_pair45_enable & pair_ok[4] & pair_ok[5];
            port_out_q <= (module_pin_use & module_pin_drive)
                | (~module_pin_use & gpio_drive);
        end
    end

    // A registered copy keeps every output straight from a flop
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            time_base_q <= `RST_COUNT;
        end else begin
            time_base_q <= count_d;
        end
    end

    // ------------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------------
    // Sticky status, write one to clear; a new event in that cycle survives
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status_q <= 2'b00;
            irq_mask_q <= 2'b00;
        end else begin
            irq_status_q[`BIT_STATUS_OVERFLOW] <= overflow
                | (irq_status_q[`BIT_STATUS_OVERFLOW]
                & ~(wr && addr == `OFS_IRQ_STATUS && wdata[`BIT_STATUS_OVERFLOW]));
            irq_status_q[`BIT_STATUS_MODULE] <= (|module_event)
                | (irq_status_q[`BIT_STATUS_MODULE]
                & ~(wr && addr == `OFS_IRQ_STATUS && wdata[`BIT_STATUS_MODULE]));
            if (wr && addr == `OFS_IRQ_MASK) begin
                irq_mask_q <= wdata[1:0];
            end
        end
    end

    // Registered request lines, one cycle behind the flags
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            overflow_irq_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            overflow_irq_q <= control_q.overflow_flag & mode_q.overflow_irq_enable;
            irq_q <= |(irq_status_q & irq_mask_q);
        end
    end

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    // Data stand only in the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= `RST_BYTE;
        end else if (!rd) begin
            rdata_q <= `RST_BYTE;
        end else begin
            unique case (addr)
                `OFS_CONTROL: rdata_q <= control_q;
                `OFS_MODE: rdata_q <= mode_q;
                `OFS_COUNT_HIGH: rdata_q <= count_q[15:8];
                `OFS_COUNT_LOW: rdata_q <= count_q[7:0];
                `OFS_RELOAD_HIGH: rdata_q <= reload_high_q;
                `OFS_RELOAD_LOW: rdata_q <= reload_low_q;
                `OFS_IRQ_STATUS: rdata_q <= {6'h00, irq_status_q};
                `OFS_IRQ_MASK: rdata_q <= {6'h00, irq_mask_q};
                `OFS_PIN_CONTROL: rdata_q <= {7'h00, pin_enable_q};
                default: rdata_q <= `RST_BYTE;
            endcase
        end
    end

endmodule : counter_array_time_base

// >>> counter_array_time_base_checker.sv
// Port-level assertions for the counter array time base
`timescale 1ns/10ps
module counter_array_time_base_checker
    import counter_array_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic reset_n, // Reset, active low
    input wire logic [7:0] addr, // Address
    input wire logic [7:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    input wire logic [7:0] rdata_q, // Read data
    input wire logic [5:0] module_event, // Module events
    input wire module_modes_t module_modes, // Module modes
    input wire logic [7:0] module_pin_use, // Pin claims
    input wire logic [7:0] module_pin_drive, // Module levels
    input wire logic [7:0] gpio_drive, // Port levels
    input wire logic [7:0] port_out_q, // Pin levels
    input wire logic [15:0] time_base_q, // Shared count
    input wire logic [7:0] capture_allowed_q, // Capture accepted
    input wire logic overflow_irq_q, // Overflow request
    input wire logic overflow_pin_q, // Toggle pin
    input wire logic overflow_pin_oe_q // Toggle pin enable
);
    // ------------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Two quiet cycles after a stop, so no count byte write can move the count
    sequence s_stop;
        wr && addr == 8'hd8 && !wdata[6] ##1 !wr ##1 !wr;
    endsequence
    sequence s_irq_held;
        !wr ##1 overflow_irq_q;
    endsequence
    sequence s_mode_rw;
        wr && addr == 8'hd9 ##1 rd && addr == 8'hd9;
    endsequence
    sequence s_event_read;
        module_event != 6'h00 ##1 !wr ##1 rd && addr == 8'hd8;
    endsequence

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    property p_stop_holds;
        s_stop |=> $stable(time_base_q);
    endproperty
    property p_flag_sticky;
        s_irq_held |=> overflow_irq_q;
    endproperty
    property p_mode_readback;
        s_mode_rw |=> rdata_q == $past(wdata, 2);
    endproperty
    property p_capture_mask;
        1'b1 |=> capture_allowed_q == ($past(module_modes.capture) & 8'h3f);
    endproperty
    property p_pin_mux;
        1'b1 |=> port_out_q == (($past(module_pin_use) & $past(module_pin_drive))
            | (~$past(module_pin_use) & $past(gpio_drive)));
    endproperty
    property p_pin_gated;
        overflow_pin_q |-> overflow_pin_oe_q;
    endproperty
    property p_event_flag;
        s_event_read |=> (rdata_q[5:0] & $past(module_event, 3)) == $past(module_event, 3);
    endproperty
    property p_irq_disabled;
        wr && addr == 8'hd9 && !wdata[0] ##1 1'b1 |=> !overflow_irq_q;
    endproperty

    a_stop_holds: assert property (p_stop_holds)
        else $error("count moved while stopped");
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("overflow request dropped without a write");
    a_mode_readback: assert property (p_mode_readback)
        else $error("mode readback differs");
    a_capture_mask: assert property (p_capture_mask)
        else $error("capture acceptance wrong");
    a_pin_mux: assert property (p_pin_mux)
        else $error("port pin level wrong");
    a_pin_gated: assert property (p_pin_gated)
        else $error("toggle pin driven while disabled");
    a_event_flag: assert property (p_event_flag)
        else $error("module flag not set by event");
    a_irq_disabled: assert property (p_irq_disabled)
        else $error("overflow request with enable clear");
endmodule : counter_array_time_base_checker

bind counter_array_time_base counter_array_time_base_checker u_checker (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .module_event(module_event), .module_modes(module_modes),
    .module_pin_use(module_pin_use), .module_pin_drive(module_pin_drive),
    .gpio_drive(gpio_drive), .port_out_q(port_out_q), .time_base_q(time_base_q),
    .capture_allowed_q(capture_allowed_q), .overflow_irq_q(overflow_irq_q),
    .overflow_pin_q(overflow_pin_q), .overflow_pin_oe_q(overflow_pin_oe_q)
);

// >>> counter_array_time_base_tb_top.sv
// Self-checking bench of the counter array time base
`timescale 1ns/10ps
`include "counter_array_params.svh"
`define CHK(nm, ex, got) \
    begin \
        total_checks++; \
        if ((got) !== (ex)) begin \
            error_cnt++; \
            $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
        end \
    end
module counter_array_time_base_tb_top
    import counter_array_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata_q;
    source_in_t sources = '0;
    logic processor_idle = 1'b0;
    logic [5:0] module_event = 6'h00;
    module_modes_t module_modes = '0;
    logic [7:0] module_pin_use = 8'h00;
    logic [7:0] module_pin_drive = 8'h00;
    logic [7:0] gpio_drive = 8'h00;
    logic [7:0] port_out_q;
    logic [15:0] time_base_q;
    logic [2:0] buffer_active_q;
    logic [7:0] capture_allowed_q;
    logic overflow_irq_q;
    logic overflow_pin_q;
    logic overflow_pin_oe_q;
    logic irq_q;
    int error_cnt = 0;
    int total_checks = 0;
    logic [15:0] t0;
    // Rows: control, mode, idle, count gain over 24 cycles
    logic [31:0] rows [11] = '{32'h40000002, 32'h4002000c, 32'h4004000c, 32'h4006000c,
        32'h4008000c, 32'h400a0018, 32'h400c000c, 32'h400e000c,
        32'h408a0100, 32'h400a0118, 32'h000a0000};

    counter_array_time_base u_counter_array_time_base (
        .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_q(rdata_q), .sources(sources), .processor_idle(processor_idle),
        .module_event(module_event), .module_modes(module_modes),
        .module_pin_use(module_pin_use), .module_pin_drive(module_pin_drive),
        .gpio_drive(gpio_drive), .port_out_q(port_out_q), .time_base_q(time_base_q),
        .buffer_active_q(buffer_active_q), .capture_allowed_q(capture_allowed_q),
        .overflow_irq_q(overflow_irq_q), .overflow_pin_q(overflow_pin_q),
        .overflow_pin_oe_q(overflow_pin_oe_q), .irq_q(irq_q)
    );

    // ------------------------------------------------------------------
    // Clock and sources
    // ------------------------------------------------------------------
    always #5 clk = ~clk;
    // Every source toggles each cycle, so each event source gives 12 per 24;
    // the mixed and master sources stay synchronous slow toggles here
    always @(posedge clk) sources <= source_in_t'(~sources);

    // ------------------------------------------------------------------
    // Bus tasks and verdict
    // ------------------------------------------------------------------
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK("rdata", ex, rdata_q)
    endtask : rd_chk

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    // Watchdog so a hang still reaches the verdict
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        rd_chk(`OFS_CONTROL, 8'h00);
        rd_chk(`OFS_MODE, 8'h00);
        wr_reg(8'h10, 8'h55);
        rd_chk(8'h10, 8'h00);
        for (int i = 0; i < 11; i++) begin
            wr_reg(`OFS_MODE, rows[i][23:16]);
            processor_idle <= rows[i][8];
            wr_reg(`OFS_CONTROL, rows[i][31:24]);
            repeat (4) @(posedge clk);
            #1;
            t0 = time_base_q;
            repeat (24) @(posedge clk);
            #1;
            `CHK("gain", rows[i][7:0], 8'(time_base_q - t0))
        end
        // Wrap from all ones must reload, flag, toggle and interrupt
        wr_reg(`OFS_RELOAD_HIGH, 8'h12);
        processor_idle <= 1'b0;
        wr_reg(`OFS_RELOAD_LOW, 8'h34);
        wr_reg(`OFS_COUNT_HIGH, 8'hff);
        wr_reg(`OFS_COUNT_LOW, 8'hff);
        // Mode write followed at once by its read, with no idle cycle between
        @(posedge clk);
        wr <= 1'b1;
        addr <= `OFS_MODE;
        wdata <= 8'h0b;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK("mode b2b", 8'h0b, rdata_q)
        wr_reg(`OFS_PIN_CONTROL, 8'h01);
        wr_reg(`OFS_IRQ_MASK, 8'h01);
        wr_reg(`OFS_CONTROL, 8'h40);
        repeat (3) @(posedge clk);
        wr_reg(`OFS_CONTROL, 8'h80);
        #1;
        `CHK("reload", 1'b1, (time_base_q - 16'h1234) <= 16'h0008)
        `CHK("ovf irq", 1'b1, overflow_irq_q)
        `CHK("irq", 1'b1, irq_q)
        `CHK("pin", 2'b11, {overflow_pin_q, overflow_pin_oe_q})
        rd_chk(`OFS_CONTROL, 8'h80);
        wr_reg(`OFS_PIN_CONTROL, 8'h00);
        settle();
        `CHK("pin off", 2'b00, {overflow_pin_q, overflow_pin_oe_q})
        wr_reg(`OFS_CONTROL, 8'h00);
        rd_chk(`OFS_CONTROL, 8'h00);
        `CHK("ovf irq clr", 1'b0, overflow_irq_q)
        wr_reg(`OFS_IRQ_STATUS, 8'h01);
        settle();
        `CHK("irq clr", 1'b0, irq_q)
        wr_reg(`OFS_CONTROL, 8'h80);
        rd_chk(`OFS_CONTROL, 8'h80);
        // Module events, masked first, then unmasked and cleared
        wr_reg(`OFS_IRQ_MASK, 8'h00);
        module_event <= 6'h21;
        @(posedge clk);
        module_event <= 6'h00;
        // Read two cycles after the event, so the checker sees the flag land
        rd_chk(`OFS_CONTROL, 8'ha1);
        `CHK("masked", 1'b0, irq_q)
        rd_chk(`OFS_IRQ_STATUS, 8'h02);
        wr_reg(`OFS_IRQ_MASK, 8'h02);
        settle();
        `CHK("unmasked", 1'b1, irq_q)
        wr_reg(`OFS_IRQ_STATUS, 8'h02);
        settle();
        `CHK("cleared", 1'b0, irq_q)
        rd_chk(`OFS_CONTROL, 8'ha1);
        // Buffer pairs, capture limits and pin sharing
        wr_reg(`OFS_MODE, 8'h70);
        module_modes <= {8'h0f, 8'h30, 8'h80};
        module_pin_use <= 8'hf0;
        module_pin_drive <= 8'haa;
        gpio_drive <= 8'h55;
        settle();
        `CHK("buffer", 3'b111, buffer_active_q)
        `CHK("capture", 8'h0f, capture_allowed_q)
        `CHK("port", 8'ha5, port_out_q)
        module_modes <= {8'hc7, 8'h00, 8'h08};
        settle();
        `CHK("buffer2", 3'b011, buffer_active_q)
        `CHK("capture2", 8'h07, capture_allowed_q)
        // Reset in mid-run returns registers to zero
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd_chk(`OFS_CONTROL, 8'h00);
        rd_chk(`OFS_MODE, 8'h00);
        print_verdict();
    end
endmodule : counter_array_time_base_tb_top
